/* alt_periph_model.sv */
// pin-change and converter peripheral model
`timescale 1ns/100ps
module alt_periph_model (
  // clock and reset
  input wire clk,
  input wire rst,
  // settings from the bench
  input wire [7:0] mask_cfg,
  input wire [7:0] conv_cfg,
  input wire grp_cfg,
  // override sources
  output wire [7:0] mask_bits,
  output wire [7:0] conv_dis,
  output wire grp_en,
  // digital tap
  input wire [7:0] tap_in,
  output logic [7:0] tap_sync_q
);
  logic [7:0] meta_q;
  assign mask_bits = mask_cfg;
  assign conv_dis = conv_cfg;
  assign grp_en = grp_cfg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 8'h00;
      tap_sync_q <= 8'h00;
    end else begin
      meta_q <= tap_in;
      tap_sync_q <= meta_q;
    end
  end
endmodule

/* pin_override_cell.v */
// one pin's override cell: pull-up, driver, value, toggle and input enable
`timescale 1ns/100ps
`include "port_pin_override_defines.vh"

module pin_override_cell (
  // register-derived pin state
  input wire dir_bit,
  input wire out_bit,
  input wire global_pullup_disable,
  input wire sleep_clamp,
  // overrides from the owning peripheral
  input wire pullup_override_en,
  input wire pullup_override_val,
  input wire dir_override_en,
  input wire dir_override_val,
  input wire outval_override_en,
  input wire outval_override_val,
  input wire toggle_override_en,
  input wire inen_override_en,
  input wire inen_override_val,
  // pad side
  input wire pad_in,
  output wire pullup_en,
  output wire drive_en,
  output wire drive_val,
  output wire toggle_req,
  output wire input_en,
  output wire alt_digital_in
);

  wire normal_pullup;

  // pull-up only for input, out one, pull-ups allowed
  assign normal_pullup = ({dir_bit, out_bit, global_pullup_disable} == `PULLUP_ON_CODE);
  assign pullup_en = pullup_override_en ? pullup_override_val : normal_pullup;

  assign drive_en = dir_override_en ? dir_override_val : dir_bit;
  assign drive_val = outval_override_en ? outval_override_val : out_bit;

  assign toggle_req = toggle_override_en;

  assign input_en = inen_override_en ? inen_override_val : ~sleep_clamp;

  // clamped low when disabled, tapped before the synchroniser
  assign alt_digital_in = input_en & pad_in;

endmodule

/* port_pin_override_defines.vh */
// constants for the port pin override logic
`ifndef PORT_PIN_OVERRIDE_DEFINES_VH
`define PORT_PIN_OVERRIDE_DEFINES_VH

// pins in the port
`define PORT_WIDTH 8
`define PORT_MSB 7

// pin indices within the port
`define PIN_0 0
`define PIN_1 1
`define PIN_2 2
`define PIN_3 3
`define PIN_4 4
`define PIN_5 5
`define PIN_6 6
`define PIN_7 7

// reset values of the port registers and pad controls
`define DIR_RESET 8'h00
`define OUT_RESET 8'h00
`define PAD_CTRL_RESET 8'h00
`define SYNC_RESET 8'h00

// forced-off override level
`define OVR_OFF 1'b0
`define OVR_OFF_BUS 8'h00

// {dir_bit, out_bit, global_pullup_disable} that turns the pull-up on
`define PULLUP_ON_CODE 3'h2

// sleep mode codes that clamp digital inputs
`define SLEEP_CODE_WIDTH 3
`define SLEEP_POWER_DOWN 3'h2
`define SLEEP_POWER_SAVE 3'h3
`define SLEEP_STANDBY 3'h6

`endif

/* port_pin_override_logic.v */
// port A pin logic with alternate-function overrides
`timescale 1ns/100ps
`include "port_pin_override_defines.vh"

// How it works
// - Pull-up override enable makes pull-up follow the override value while the driver is disabled.
// - Without override, pull-up is on only for input, out one, not disabled.
// - Under pull-up override, value one turns pull-up on unless the driver is enabled, zero off.
// - Direction override enable makes driver enable follow the override value.
// - Without direction override, driver enable equals the direction bit.
// - Under direction override, value one enables driver, zero disables.
// - Without value override, the driven level is the out bit.
// - Toggle override enable inverts the out bit.
// - Input-enable override makes digital input enable follow its value.
// - Without input override, input enable follows normal or clamping sleep state.
// - Under input override, value one enables input, zero disables.
// - Peripheral digital input tapped before synchroniser; peripheral synchronises it.
// - Analog connection wired straight to the pad, bypassing digital logic.
// - Port A pull-up, direction and value overrides are held at zero.
// - Input override enable is mask AND group0 OR converter disable; value is the AND.
// - Pins 7..0 feed pin-change sources 7..0 and converter channels 7..0.
// - Global pull-up disable turns off all non-overridden pull-ups.
// - Writing one to a pin input bit inverts its out bit.
// - Power-down, power-save and standby clamp digital inputs.
module port_pin_override_logic (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // direction register write and read
  input wire DIR_WR_EN,
  input wire [`PORT_MSB:0] DIR_WR_DATA,
  output reg [`PORT_MSB:0] DIR_BIT,
  // output register write and read
  input wire OUT_WR_EN,
  input wire [`PORT_MSB:0] OUT_WR_DATA,
  output reg [`PORT_MSB:0] OUT_BIT,
  // input register: write toggles, read is synchronised pad gated by input enable
  input wire PIN_IN_WR_EN,
  input wire [`PORT_MSB:0] PIN_IN_WR_DATA,
  output reg [`PORT_MSB:0] PIN_IN_BIT,
  // global control
  input wire GLOBAL_PULLUP_DISABLE,
  input wire [`SLEEP_CODE_WIDTH-1:0] SLEEP_MODE,
  input wire SLEEP_ACTIVE,
  // pin-change and converter controls
  input wire [`PORT_MSB:0] PIN_CHANGE_MASK_BITS,
  input wire PIN_CHANGE_GROUP0_EN,
  input wire [`PORT_MSB:0] CONV_INPUT_DISABLE_BIT,
  // alternate-function taps
  output wire [`PORT_MSB:0] PIN_CHANGE_SRC,
  output wire [`PORT_MSB:0] CONV_CHANNEL_IN,
  // pad side
  input wire [`PORT_MSB:0] PAD_IN,
  input wire [`PORT_MSB:0] PAD_ANALOG,
  output reg [`PORT_MSB:0] PAD_PULLUP_EN,
  output reg [`PORT_MSB:0] PAD_DRIVE_EN,
  output reg [`PORT_MSB:0] PAD_DRIVE_VAL,
  output reg [`PORT_MSB:0] PAD_INPUT_EN
);

  // clamping sleep modes
  function sleep_clamps;
    input active;
    input [`SLEEP_CODE_WIDTH-1:0] mode;
    begin
      case (mode)
        `SLEEP_POWER_DOWN: sleep_clamps = active;
        `SLEEP_POWER_SAVE: sleep_clamps = active;
        `SLEEP_STANDBY: sleep_clamps = active;
        default: sleep_clamps = 1'b0;
      endcase
    end
  endfunction

  wire sleep_clamp;
  wire [`PORT_MSB:0] pc_term;
  wire [`PORT_MSB:0] inen_ovr_en;
  wire [`PORT_MSB:0] inen_ovr_val;
  wire [`PORT_MSB:0] pullup_en;
  wire [`PORT_MSB:0] drive_en;
  wire [`PORT_MSB:0] drive_val;
  wire [`PORT_MSB:0] toggle_req;
  wire [`PORT_MSB:0] input_en;
  wire [`PORT_MSB:0] alt_digital_in;
  reg [`PORT_MSB:0] dir_d;
  reg [`PORT_MSB:0] out_d;
  reg [`PORT_MSB:0] sync1_q;

  assign sleep_clamp = sleep_clamps(SLEEP_ACTIVE, SLEEP_MODE);

  // port A input override terms
  assign pc_term = PIN_CHANGE_MASK_BITS & {`PORT_WIDTH{PIN_CHANGE_GROUP0_EN}};
  assign inen_ovr_en = pc_term | CONV_INPUT_DISABLE_BIT;
  assign inen_ovr_val = pc_term;

  // one cell per pin, unused overrides tied low

  // pin 0: pin-change source 0, converter channel 0
  pin_override_cell u_cell_0 (
    .dir_bit(DIR_BIT[`PIN_0]),
    .out_bit(OUT_BIT[`PIN_0]),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .sleep_clamp(sleep_clamp),
    .pullup_override_en(`OVR_OFF),
    .pullup_override_val(`OVR_OFF),
    .dir_override_en(`OVR_OFF),
    .dir_override_val(`OVR_OFF),
    .outval_override_en(`OVR_OFF),
    .outval_override_val(`OVR_OFF),
    .toggle_override_en(`OVR_OFF),
    .inen_override_en(inen_ovr_en[`PIN_0]),
    .inen_override_val(inen_ovr_val[`PIN_0]),
    .pad_in(PAD_IN[`PIN_0]),
    .pullup_en(pullup_en[`PIN_0]),
    .drive_en(drive_en[`PIN_0]),
    .drive_val(drive_val[`PIN_0]),
    .toggle_req(toggle_req[`PIN_0]),
    .input_en(input_en[`PIN_0]),
    .alt_digital_in(alt_digital_in[`PIN_0])
  );

  // pin 1: pin-change source 1, converter channel 1
  pin_override_cell u_cell_1 (
    .dir_bit(DIR_BIT[`PIN_1]),
    .out_bit(OUT_BIT[`PIN_1]),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .sleep_clamp(sleep_clamp),
    .pullup_override_en(`OVR_OFF),
    .pullup_override_val(`OVR_OFF),
    .dir_override_en(`OVR_OFF),
    .dir_override_val(`OVR_OFF),
    .outval_override_en(`OVR_OFF),
    .outval_override_val(`OVR_OFF),
    .toggle_override_en(`OVR_OFF),
    .inen_override_en(inen_ovr_en[`PIN_1]),
    .inen_override_val(inen_ovr_val[`PIN_1]),
    .pad_in(PAD_IN[`PIN_1]),
    .pullup_en(pullup_en[`PIN_1]),
    .drive_en(drive_en[`PIN_1]),
    .drive_val(drive_val[`PIN_1]),
    .toggle_req(toggle_req[`PIN_1]),
    .input_en(input_en[`PIN_1]),
    .alt_digital_in(alt_digital_in[`PIN_1])
  );

  // pin 2: pin-change source 2, converter channel 2
  pin_override_cell u_cell_2 (
    .dir_bit(DIR_BIT[`PIN_2]),
    .out_bit(OUT_BIT[`PIN_2]),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .sleep_clamp(sleep_clamp),
    .pullup_override_en(`OVR_OFF),
    .pullup_override_val(`OVR_OFF),
    .dir_override_en(`OVR_OFF),
    .dir_override_val(`OVR_OFF),
    .outval_override_en(`OVR_OFF),
    .outval_override_val(`OVR_OFF),
    .toggle_override_en(`OVR_OFF),
    .inen_override_en(inen_ovr_en[`PIN_2]),
    .inen_override_val(inen_ovr_val[`PIN_2]),
    .pad_in(PAD_IN[`PIN_2]),
    .pullup_en(pullup_en[`PIN_2]),
    .drive_en(drive_en[`PIN_2]),
    .drive_val(drive_val[`PIN_2]),
    .toggle_req(toggle_req[`PIN_2]),
    .input_en(input_en[`PIN_2]),
    .alt_digital_in(alt_digital_in[`PIN_2])
  );

  // pin 3: pin-change source 3, converter channel 3
  pin_override_cell u_cell_3 (
    .dir_bit(DIR_BIT[`PIN_3]),
    .out_bit(OUT_BIT[`PIN_3]),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .sleep_clamp(sleep_clamp),
    .pullup_override_en(`OVR_OFF),
    .pullup_override_val(`OVR_OFF),
    .dir_override_en(`OVR_OFF),
    .dir_override_val(`OVR_OFF),
    .outval_override_en(`OVR_OFF),
    .outval_override_val(`OVR_OFF),
    .toggle_override_en(`OVR_OFF),
    .inen_override_en(inen_ovr_en[`PIN_3]),
    .inen_override_val(inen_ovr_val[`PIN_3]),
    .pad_in(PAD_IN[`PIN_3]),
    .pullup_en(pullup_en[`PIN_3]),
    .drive_en(drive_en[`PIN_3]),
    .drive_val(drive_val[`PIN_3]),
    .toggle_req(toggle_req[`PIN_3]),
    .input_en(input_en[`PIN_3]),
    .alt_digital_in(alt_digital_in[`PIN_3])
  );

  // pin 4: pin-change source 4, converter channel 4
  pin_override_cell u_cell_4 (
    .dir_bit(DIR_BIT[`PIN_4]),
    .out_bit(OUT_BIT[`PIN_4]),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .sleep_clamp(sleep_clamp),
    .pullup_override_en(`OVR_OFF),
    .pullup_override_val(`OVR_OFF),
    .dir_override_en(`OVR_OFF),
    .dir_override_val(`OVR_OFF),
    .outval_override_en(`OVR_OFF),
    .outval_override_val(`OVR_OFF),
    .toggle_override_en(`OVR_OFF),
    .inen_override_en(inen_ovr_en[`PIN_4]),
    .inen_override_val(inen_ovr_val[`PIN_4]),
    .pad_in(PAD_IN[`PIN_4]),
    .pullup_en(pullup_en[`PIN_4]),
    .drive_en(drive_en[`PIN_4]),
    .drive_val(drive_val[`PIN_4]),
    .toggle_req(toggle_req[`PIN_4]),
    .input_en(input_en[`PIN_4]),
    .alt_digital_in(alt_digital_in[`PIN_4])
  );

  // pin 5: pin-change source 5, converter channel 5
  pin_override_cell u_cell_5 (
    .dir_bit(DIR_BIT[`PIN_5]),
    .out_bit(OUT_BIT[`PIN_5]),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .sleep_clamp(sleep_clamp),
    .pullup_override_en(`OVR_OFF),
    .pullup_override_val(`OVR_OFF),
    .dir_override_en(`OVR_OFF),
    .dir_override_val(`OVR_OFF),
    .outval_override_en(`OVR_OFF),
    .outval_override_val(`OVR_OFF),
    .toggle_override_en(`OVR_OFF),
    .inen_override_en(inen_ovr_en[`PIN_5]),
    .inen_override_val(inen_ovr_val[`PIN_5]),
    .pad_in(PAD_IN[`PIN_5]),
    .pullup_en(pullup_en[`PIN_5]),
    .drive_en(drive_en[`PIN_5]),
    .drive_val(drive_val[`PIN_5]),
    .toggle_req(toggle_req[`PIN_5]),
    .input_en(input_en[`PIN_5]),
    .alt_digital_in(alt_digital_in[`PIN_5])
  );

  // pin 6: pin-change source 6, converter channel 6
  pin_override_cell u_cell_6 (
    .dir_bit(DIR_BIT[`PIN_6]),
    .out_bit(OUT_BIT[`PIN_6]),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .sleep_clamp(sleep_clamp),
    .pullup_override_en(`OVR_OFF),
    .pullup_override_val(`OVR_OFF),
    .dir_override_en(`OVR_OFF),
    .dir_override_val(`OVR_OFF),
    .outval_override_en(`OVR_OFF),
    .outval_override_val(`OVR_OFF),
    .toggle_override_en(`OVR_OFF),
    .inen_override_en(inen_ovr_en[`PIN_6]),
    .inen_override_val(inen_ovr_val[`PIN_6]),
    .pad_in(PAD_IN[`PIN_6]),
    .pullup_en(pullup_en[`PIN_6]),
    .drive_en(drive_en[`PIN_6]),
    .drive_val(drive_val[`PIN_6]),
    .toggle_req(toggle_req[`PIN_6]),
    .input_en(input_en[`PIN_6]),
    .alt_digital_in(alt_digital_in[`PIN_6])
  );

  // pin 7: pin-change source 7, converter channel 7
  pin_override_cell u_cell_7 (
    .dir_bit(DIR_BIT[`PIN_7]),
    .out_bit(OUT_BIT[`PIN_7]),
    .global_pullup_disable(GLOBAL_PULLUP_DISABLE),
    .sleep_clamp(sleep_clamp),
    .pullup_override_en(`OVR_OFF),
    .pullup_override_val(`OVR_OFF),
    .dir_override_en(`OVR_OFF),
    .dir_override_val(`OVR_OFF),
    .outval_override_en(`OVR_OFF),
    .outval_override_val(`OVR_OFF),
    .toggle_override_en(`OVR_OFF),
    .inen_override_en(inen_ovr_en[`PIN_7]),
    .inen_override_val(inen_ovr_val[`PIN_7]),
    .pad_in(PAD_IN[`PIN_7]),
    .pullup_en(pullup_en[`PIN_7]),
    .drive_en(drive_en[`PIN_7]),
    .drive_val(drive_val[`PIN_7]),
    .toggle_req(toggle_req[`PIN_7]),
    .input_en(input_en[`PIN_7]),
    .alt_digital_in(alt_digital_in[`PIN_7])
  );

  // unsynchronised taps, receivers synchronise them
  assign PIN_CHANGE_SRC = alt_digital_in;
  // straight pad connection, no digital stage
  assign CONV_CHANNEL_IN = PAD_ANALOG;

  // register next values
  always @* begin
    dir_d = DIR_WR_EN ? DIR_WR_DATA : DIR_BIT;
    out_d = OUT_WR_EN ? OUT_WR_DATA : OUT_BIT;
    // write-one toggle, any direction
    if (PIN_IN_WR_EN) begin
      out_d = out_d ^ PIN_IN_WR_DATA;
    end
    out_d = out_d ^ toggle_req;
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DIR_BIT <= `DIR_RESET;
      OUT_BIT <= `OUT_RESET;
    end else begin
      DIR_BIT <= dir_d;
      OUT_BIT <= out_d;
    end
  end

  // two-stage synchroniser for the pin read
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= `SYNC_RESET;
      PIN_IN_BIT <= `SYNC_RESET;
    end else begin
      sync1_q <= alt_digital_in;
      PIN_IN_BIT <= sync1_q;
    end
  end

  // registered pad controls, tri-stated under reset
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PAD_PULLUP_EN <= `PAD_CTRL_RESET;
      PAD_DRIVE_EN <= `PAD_CTRL_RESET;
      PAD_DRIVE_VAL <= `PAD_CTRL_RESET;
      PAD_INPUT_EN <= `PAD_CTRL_RESET;
    end else begin
      PAD_PULLUP_EN <= pullup_en & ~drive_en;
      PAD_DRIVE_EN <= drive_en;
      PAD_DRIVE_VAL <= drive_val & drive_en;
      PAD_INPUT_EN <= input_en;
    end
  end

endmodule

/* port_pin_override_logic_sva.sv */
// assertion checker for the port pin override logic
`timescale 1ns/100ps
`include "port_pin_override_defines.vh"
module port_pin_chk (
  // clock, reset and strobes
  input wire CORE_CLK, RST, DIR_WR_EN, OUT_WR_EN, PIN_IN_WR_EN,
  // control levels
  input wire GLOBAL_PULLUP_DISABLE, SLEEP_ACTIVE, PIN_CHANGE_GROUP0_EN,
  input wire [2:0] SLEEP_MODE,
  // byte buses
  input wire [7:0] DIR_WR_DATA, OUT_WR_DATA, PIN_IN_WR_DATA, DIR_BIT, OUT_BIT, PIN_IN_BIT,
  input wire [7:0] PIN_CHANGE_MASK_BITS, CONV_INPUT_DISABLE_BIT, PIN_CHANGE_SRC, CONV_CHANNEL_IN,
  input wire [7:0] PAD_IN, PAD_ANALOG, PAD_PULLUP_EN, PAD_DRIVE_EN, PAD_DRIVE_VAL, PAD_INPUT_EN
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire clamp = SLEEP_ACTIVE && (SLEEP_MODE == `SLEEP_POWER_DOWN || SLEEP_MODE == `SLEEP_POWER_SAVE
    || SLEEP_MODE == `SLEEP_STANDBY);
  wire [7:0] pc = PIN_CHANGE_MASK_BITS & {8{PIN_CHANGE_GROUP0_EN}};
  wire [7:0] ien = pc | (~(pc | CONV_INPUT_DISABLE_BIT) & {8{~clamp}});
  wire [7:0] out_nx = (OUT_WR_EN ? OUT_WR_DATA : OUT_BIT) ^ (PIN_IN_WR_EN ? PIN_IN_WR_DATA : 8'h00);
  property p_drv; !$past(RST) |-> PAD_DRIVE_EN == $past(DIR_BIT); endproperty
  property p_pu; !$past(RST) |-> PAD_PULLUP_EN == $past(~DIR_BIT & OUT_BIT & {8{~GLOBAL_PULLUP_DISABLE}}); endproperty
  property p_val; !$past(RST) |-> PAD_DRIVE_VAL == $past(DIR_BIT & OUT_BIT); endproperty
  property p_ien; !$past(RST) |-> PAD_INPUT_EN == $past(ien); endproperty
  // tap follows the live input enable, not the registered pad copy
  property p_tap; PIN_CHANGE_SRC == (PAD_IN & ien); endproperty
  property p_ana; CONV_CHANNEL_IN == PAD_ANALOG; endproperty
  property p_out; 1'b1 |=> OUT_BIT == $past(out_nx); endproperty
  property p_dir; DIR_WR_EN |=> DIR_BIT == $past(DIR_WR_DATA); endproperty
  property p_sync; !$past(RST) && !$past(RST, 2) |-> PIN_IN_BIT == $past(PIN_CHANGE_SRC, 2); endproperty
  a_drv: assert property (p_drv) else $error("drive enable wrong");
  a_pu: assert property (p_pu) else $error("pull-up wrong");
  a_val: assert property (p_val) else $error("drive level wrong");
  a_ien: assert property (p_ien) else $error("input enable wrong");
  a_tap: assert property (p_tap) else $error("digital tap wrong");
  a_ana: assert property (p_ana) else $error("analog tap wrong");
  a_out: assert property (p_out) else $error("output register wrong");
  a_dir: assert property (p_dir) else $error("direction register wrong");
  a_sync: assert property (p_sync) else $error("synchronised read wrong");
  c_pu: cover property (PAD_PULLUP_EN != 8'h00);
  c_clamp: cover property (clamp && PAD_INPUT_EN != 8'h00);
  c_tgl: cover property (PIN_IN_WR_EN && OUT_WR_EN);
endmodule
bind port_pin_override_logic port_pin_chk u_chk (.*);

/* testbench.sv */
// testbench for the port pin override logic
`timescale 1ns/100ps
module testbench;
  logic CORE_CLK = 0, RST = 1, DIR_WR_EN = 0, OUT_WR_EN = 0, PIN_IN_WR_EN = 0, GLOBAL_PULLUP_DISABLE = 0;
  logic SLEEP_ACTIVE = 0, grp_cfg = 0, PIN_CHANGE_GROUP0_EN;
  logic [2:0] SLEEP_MODE = 3'h0;
  logic [2:0] modes [4] = '{3'h1, 3'h2, 3'h3, 3'h6};
  logic [7:0] DIR_WR_DATA = 8'h00, OUT_WR_DATA = 8'h00, PIN_IN_WR_DATA = 8'h00, PAD_IN = 8'h00;
  logic [7:0] PAD_ANALOG = 8'h00, mask_cfg = 8'h00, conv_cfg = 8'h00, tap_sync;
  logic [7:0] PIN_CHANGE_MASK_BITS, CONV_INPUT_DISABLE_BIT, DIR_BIT, OUT_BIT, PIN_IN_BIT, PIN_CHANGE_SRC;
  logic [7:0] CONV_CHANNEL_IN, PAD_PULLUP_EN, PAD_DRIVE_EN, PAD_DRIVE_VAL, PAD_INPUT_EN;
  integer n_errors = 0, checks_done = 0;
  always #10 CORE_CLK = ~CORE_CLK;
  port_pin_override_logic DUT (.*);
  alt_periph_model PEER (.clk(CORE_CLK), .rst(RST), .mask_cfg(mask_cfg), .conv_cfg(conv_cfg),
    .grp_cfg(grp_cfg), .mask_bits(PIN_CHANGE_MASK_BITS), .conv_dis(CONV_INPUT_DISABLE_BIT),
    .grp_en(PIN_CHANGE_GROUP0_EN), .tap_in(PIN_CHANGE_SRC), .tap_sync_q(tap_sync));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one-cycle strobe: bit 0 direction, bit 1 output, bit 2 toggle
  task wr(input logic [2:0] sel, input logic [7:0] d);
    @(negedge CORE_CLK);
    {PIN_IN_WR_EN, OUT_WR_EN, DIR_WR_EN} = sel;
    DIR_WR_DATA = d;
    OUT_WR_DATA = d;
    PIN_IN_WR_DATA = d;
    @(negedge CORE_CLK);
    {PIN_IN_WR_EN, OUT_WR_EN, DIR_WR_EN} = 3'h0;
  endtask
  task tick(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  initial begin
    tick(4);
    chk(PAD_PULLUP_EN | PAD_DRIVE_EN | PAD_INPUT_EN | OUT_BIT, 8'h00);
    RST = 0;
    wr(3'h2, 8'h0F);
    wr(3'h1, 8'h33);
    tick(1);
    chk(DIR_BIT, 8'h33);
    chk(PAD_PULLUP_EN, 8'h0C);
    chk(PAD_DRIVE_EN, 8'h33);
    chk(PAD_DRIVE_VAL, 8'h03);
    GLOBAL_PULLUP_DISABLE = 1;
    tick(2);
    chk(PAD_PULLUP_EN, 8'h00);
    wr(3'h4, 8'h3C);
    chk(OUT_BIT, 8'h33);
    wr(3'h6, 8'h55);
    chk(OUT_BIT, 8'h00);
    PAD_IN = 8'hA5;
    PAD_ANALOG = 8'h5A;
    conv_cfg = 8'h0F;
    tick(4);
    chk(PAD_INPUT_EN, 8'hF0);
    chk(PIN_CHANGE_SRC, 8'hA0);
    chk(CONV_CHANNEL_IN, 8'h5A);
    chk(PIN_IN_BIT, 8'hA0);
    chk(tap_sync, 8'hA0);
    SLEEP_ACTIVE = 1;
    mask_cfg = 8'h81;
    grp_cfg = 1;
    for (int i = 0; i < 4; i++) begin
      SLEEP_MODE = modes[i];
      tick(2);
      chk(PAD_INPUT_EN, (i == 0) ? 8'hF1 : 8'h81);
    end
    grp_cfg = 0;
    tick(2);
    chk(PAD_INPUT_EN, 8'h00);
    // clamping code with sleep not active leaves inputs on
    SLEEP_ACTIVE = 0;
    tick(2);
    chk(PAD_INPUT_EN, 8'hF0);
    finish_test;
  end
  initial begin
    #20000;
    n_errors++;
    finish_test;
  end
endmodule
